// ### mpc_maint_panel.sv
`timescale 1ns/1ps
`include "mpc_defines.svh"

// Notes on behaviour
// - panel acts only in local mode
// - lamps show selected word and pointer, word lamps blanked by clear
// - load writes data switches, pointer advances
// - clear with display on zeroes word
// - clear with display off: pointer zero
// - start runs one stored instruction
// - step advances pointer only when idle or halted
// - check error stops run when enabled
// - one sector: single pass or repeat
// - slip switch requests a slip
// - alternate mode: starts take turns
// - alternate loop sector: endless swapping
// - alternate loop: run other once
// - error in alternate loop: run other
// - repeat head or sector to sequencer
// - inhibit overlapped seek in local
// - keep address or clear on restart
// - instructions at words 0 and 8
module mpc_maint_panel (
	input wire logic clock,
	input wire logic arst_n,
	input mpc_pkg::mpc_wb_req_s wb_req,
	output mpc_pkg::mpc_wb_rsp_s wb_rsp,
	input wire logic [`MPC_NUM_BTN-1:0] panel_buttons,
	input wire logic [`MPC_NUM_SW-1:0] panel_switches,
	input wire logic [`MPC_WORD_W-1:0] data_switches,
	input wire logic op_done,
	input wire logic check_error,
	output mpc_pkg::mpc_exec_s exec,
	output mpc_pkg::mpc_mode_s mode,
	output logic [`MPC_WORD_W-1:0] display_lamps,
	output logic [`MPC_PTR_W-1:0] pointer_lamps
);

	// ==========================================================
	// reset release
	logic [1:0] rst_sync_ff;
	logic rst_n;

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end

	assign rst_n = rst_sync_ff[1];

	// ==========================================================
	// panel pins
	logic [`MPC_PIN_W-1:0] pin_level;
	logic [`MPC_PIN_W-1:0] pin_rise;
	logic [`MPC_NUM_BTN-1:0] btn;
	logic [`MPC_NUM_SW-1:0] sw;
	logic [`MPC_WORD_W-1:0] data_in;

	mpc_panel_sync u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.pins({data_switches, panel_switches, panel_buttons}),
		.level(pin_level),
		.rise(pin_rise)
	);

	mpc_pkg::mpc_main_s q_ff;
	mpc_pkg::mpc_main_s nxt_q;

	// buttons are dead while the controller is remote
	assign btn = pin_rise[`MPC_SW_LSB-1:`MPC_BTN_LSB] & {`MPC_NUM_BTN{q_ff.local_mode}};
	assign sw = pin_level[`MPC_DATA_LSB-1:`MPC_SW_LSB];
	assign data_in = pin_level[`MPC_PIN_W-1:`MPC_DATA_LSB];

	// ==========================================================
	// helpers
	function automatic logic [`MPC_PTR_W-1:0] inc_ptr(
		logic [`MPC_PTR_W-1:0] p
	);
		return p + 4'h1;
	endfunction : inc_ptr

	// load the sequencer with the three words of one instruction
	function automatic mpc_pkg::mpc_main_s launch(
		mpc_pkg::mpc_main_s s,
		logic second,
		logic clr
	);
		logic [`MPC_PTR_W-1:0] b;
		b = second ? `MPC_INSTR2_BASE : `MPC_INSTR1_BASE;
		s.st = mpc_pkg::st_run;
		s.ex.start = 1'b1;
		s.ex.second = second;
		s.ex.addr_clear = clr;
		s.ex.op_word = s.mem[b];
		s.ex.addr_word = s.mem[b + 4'h1];
		s.ex.data_word = s.mem[b + 4'h2];
		return s;
	endfunction : launch

	function automatic logic [31:0] read_word(
		mpc_pkg::mpc_main_s s,
		logic [7:0] a
	);
		logic [31:0] r;
		r = 32'h0;
		if (a[7:6] == `MPC_MEM_WIN_TAG) begin
			r = {16'h0, s.mem[a[5:2]]};
		end else if (a == `MPC_REG_CTRL) begin
			r = {31'h0, s.local_mode};
		end else if (a == `MPC_REG_STATUS) begin
			r = {s.disp, 5'h0, s.halted_err, s.chained, s.next2,
				s.ex.second, s.st, s.ptr};
		end
		return r;
	endfunction : read_word

	// ==========================================================
	// panel and execution sequencing
	always_comb begin
		nxt_q = q_ff;
		nxt_q.ex.start = 1'b0;
		nxt_q.ex.abort = 1'b0;
		nxt_q.ex.addr_clear = 1'b0;
		nxt_q.ack = 1'b0;
		// mode switches only reach the sequencer in local mode
		nxt_q.md.stop_on_check_error =
			q_ff.local_mode & sw[`MPC_SW_STOP_ERR];
		nxt_q.md.one_sector_only = q_ff.local_mode & sw[`MPC_SW_ONE_SECT];
		nxt_q.md.repeat_head_or_sector =
			q_ff.local_mode & sw[`MPC_SW_HEAD_SECT];
		nxt_q.md.overlap_seek_inhibit =
			q_ff.local_mode & sw[`MPC_SW_OVL_INH];
		nxt_q.md.slip_request = q_ff.local_mode & sw[`MPC_SW_SLIP];

		case (q_ff.st)
			mpc_pkg::st_idle, mpc_pkg::st_halt: begin
				if (btn[`MPC_BTN_LOAD]) begin
					nxt_q.mem[q_ff.ptr] = data_in;
					nxt_q.ptr = inc_ptr(q_ff.ptr);
					nxt_q.disp = q_ff.mem[inc_ptr(q_ff.ptr)];
				end else if (btn[`MPC_BTN_CLEAR]) begin
					nxt_q.disp = '0;
					if (sw[`MPC_SW_DISPLAY]) begin
						nxt_q.mem[q_ff.ptr] = '0;
					end else begin
						nxt_q.ptr = '0;
						// clearing also forgets whose turn it is
						nxt_q.next2 = 1'b0;
					end
				end else if (btn[`MPC_BTN_STEP]) begin
					if (sw[`MPC_SW_DISPLAY]) begin
						nxt_q.ptr = inc_ptr(q_ff.ptr);
						nxt_q.disp = q_ff.mem[inc_ptr(q_ff.ptr)];
					end
				end else if (btn[`MPC_BTN_START]) begin
					nxt_q = launch(nxt_q, sw[`MPC_SW_ALT] & q_ff.next2,
						!sw[`MPC_SW_KEEP_ADDR]);
					nxt_q.next2 = sw[`MPC_SW_ALT] & !q_ff.next2;
					nxt_q.chained = 1'b0;
					nxt_q.halted_err = 1'b0;
				end
			end
			mpc_pkg::st_run: begin
				if (btn[`MPC_BTN_STOP]) begin
					nxt_q.ex.abort = 1'b1;
					nxt_q.st = mpc_pkg::st_idle;
				end else if (check_error & q_ff.md.stop_on_check_error) begin
					nxt_q.ex.abort = 1'b1;
					nxt_q.halted_err = 1'b1;
					if (sw[`MPC_SW_ALT] & sw[`MPC_SW_REPEAT] & !q_ff.chained) begin
						nxt_q = launch(nxt_q, !q_ff.ex.second, 1'b0);
						nxt_q.chained = !sw[`MPC_SW_ONE_SECT];
					end else begin
						nxt_q.st = mpc_pkg::st_halt;
					end
				end else if (op_done) begin
					if (sw[`MPC_SW_ONE_SECT] & sw[`MPC_SW_REPEAT]) begin
						// alternate swaps cylinders, else same sector again
						nxt_q = launch(nxt_q,
							q_ff.ex.second ^ sw[`MPC_SW_ALT], 1'b0);
					end else if (sw[`MPC_SW_ALT] & sw[`MPC_SW_REPEAT] &
						!q_ff.chained) begin
						nxt_q = launch(nxt_q, !q_ff.ex.second, 1'b0);
						nxt_q.chained = 1'b1;
					end else begin
						nxt_q.st = mpc_pkg::st_idle;
					end
				end
			end
			default: begin
				nxt_q.st = mpc_pkg::st_idle;
			end
		endcase

		// wishbone slave, one wait state, unmapped reads give zero
		if (wb_req.cyc & wb_req.stb & !q_ff.ack) begin
			nxt_q.ack = 1'b1;
			nxt_q.rdat = read_word(q_ff, wb_req.adr);
			if (wb_req.we & wb_req.sel[0] & (wb_req.adr == `MPC_REG_CTRL)) begin
				nxt_q.local_mode = wb_req.dat[`MPC_CTRL_LOCAL];
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= '0;
			q_ff.st <= mpc_pkg::st_idle;
			q_ff.local_mode <= `MPC_CTRL_RST;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign wb_rsp = {q_ff.ack, q_ff.rdat};
	assign exec = q_ff.ex;
	assign mode = q_ff.md;
	assign display_lamps = q_ff.disp;
	assign pointer_lamps = q_ff.ptr;

	// ==========================================================
	// checks
	logic not_run;
	assign not_run = (q_ff.st != mpc_pkg::st_run);

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	property p_remote_inert;
		(!q_ff.local_mode && not_run && !wb_req.cyc) |=>
			($stable(q_ff.ptr) && $stable(q_ff.mem) && !q_ff.ex.start);
	endproperty
	a_remote_inert: assert property (p_remote_inert)
		else $error("panel changed state while remote");

	property p_load;
		(btn[`MPC_BTN_LOAD] && not_run) |=>
			(q_ff.ptr == 4'($past(q_ff.ptr) + 4'h1)) &&
			(q_ff.mem[$past(q_ff.ptr)] == $past(data_in));
	endproperty
	a_load: assert property (p_load)
		else $error("load did not store word and advance pointer");

	property p_clear_on;
		(btn[`MPC_BTN_CLEAR] && !btn[`MPC_BTN_LOAD] && not_run &&
			sw[`MPC_SW_DISPLAY]) |=>
			(q_ff.disp == '0) && (q_ff.mem[$past(q_ff.ptr)] == '0) &&
			$stable(q_ff.ptr);
	endproperty
	a_clear_on: assert property (p_clear_on)
		else $error("clear with display on failed");

	property p_clear_off;
		(btn[`MPC_BTN_CLEAR] && !btn[`MPC_BTN_LOAD] && not_run &&
			!sw[`MPC_SW_DISPLAY]) |=>
			(q_ff.ptr == '0) && (q_ff.disp == '0) && $stable(q_ff.mem);
	endproperty
	a_clear_off: assert property (p_clear_off)
		else $error("clear with display off failed");

	property p_step_dead;
		(btn[`MPC_BTN_STEP] && !sw[`MPC_SW_DISPLAY] &&
			!(btn[`MPC_BTN_LOAD] | btn[`MPC_BTN_CLEAR])) |=>
			$stable(q_ff.ptr);
	endproperty
	a_step_dead: assert property (p_step_dead)
		else $error("step moved pointer with display off");

	property p_wrap;
		(q_ff.ptr == 4'hF && btn[`MPC_BTN_STEP] && sw[`MPC_SW_DISPLAY] &&
			not_run && !(btn[`MPC_BTN_LOAD] | btn[`MPC_BTN_CLEAR])) |=>
			(q_ff.ptr == 4'h0) && (q_ff.disp == q_ff.mem[0]);
	endproperty
	a_wrap: assert property (p_wrap)
		else $error("pointer did not wrap to zero");

	property p_words;
		q_ff.ex.start |-> (q_ff.st == mpc_pkg::st_run) &&
			(q_ff.ex.op_word ==
			q_ff.mem[q_ff.ex.second ? `MPC_INSTR2_BASE : `MPC_INSTR1_BASE]);
	endproperty
	a_words: assert property (p_words)
		else $error("launched wrong instruction words");

	property p_err_stop;
		(q_ff.st == mpc_pkg::st_run && check_error &&
			q_ff.md.stop_on_check_error && !btn[`MPC_BTN_STOP]) |=>
			q_ff.ex.abort && q_ff.halted_err;
	endproperty
	a_err_stop: assert property (p_err_stop)
		else $error("check error did not stop execution");

	property p_addr_clear;
		(not_run && btn[`MPC_BTN_START] && !sw[`MPC_SW_KEEP_ADDR] &&
			!(btn[`MPC_BTN_LOAD] | btn[`MPC_BTN_CLEAR] |
			btn[`MPC_BTN_STEP])) |=>
			q_ff.ex.start && q_ff.ex.addr_clear;
	endproperty
	a_addr_clear: assert property (p_addr_clear)
		else $error("restart did not clear address");

	property p_single;
		(q_ff.st == mpc_pkg::st_run && op_done && !check_error &&
			!btn[`MPC_BTN_STOP] && sw[`MPC_SW_ONE_SECT] &&
			!sw[`MPC_SW_REPEAT]) |=>
			(q_ff.st == mpc_pkg::st_idle) ##1 !q_ff.ex.start;
	endproperty
	a_single: assert property (p_single)
		else $error("single sector run did not terminate");

	property p_slip;
		q_ff.md.slip_request |-> $past(q_ff.local_mode);
	endproperty
	a_slip: assert property (p_slip)
		else $error("slip requested while remote");

	c_load: cover property (btn[`MPC_BTN_LOAD] ##1 q_ff.ptr != 4'h0);
	c_chain: cover property (q_ff.ex.start && q_ff.chained);
	c_halt: cover property (q_ff.st == mpc_pkg::st_halt);
	c_loop: cover property (op_done ##1 q_ff.ex.start);

endmodule : mpc_maint_panel

// ### mpc_defines.svh
`ifndef MPC_DEFINES_SVH
`define MPC_DEFINES_SVH

// ==========================================================
// sizes
`define MPC_WORD_W 16
`define MPC_PTR_W 4
`define MPC_NUM_BTN 5
`define MPC_NUM_SW 9
`define MPC_PIN_W 30

// ==========================================================
// instruction locations in maintenance memory
`define MPC_INSTR1_BASE 4'h0
`define MPC_INSTR2_BASE 4'h8

// ==========================================================
// pin vector layout: buttons, switches, data switches
`define MPC_BTN_LSB 0
`define MPC_SW_LSB 5
`define MPC_DATA_LSB 14

// button bits
`define MPC_BTN_LOAD 0
`define MPC_BTN_CLEAR 1
`define MPC_BTN_STEP 2
`define MPC_BTN_START 3
`define MPC_BTN_STOP 4

// switch bits
`define MPC_SW_DISPLAY 0
`define MPC_SW_STOP_ERR 1
`define MPC_SW_ONE_SECT 2
`define MPC_SW_ALT 3
`define MPC_SW_REPEAT 4
`define MPC_SW_HEAD_SECT 5
`define MPC_SW_OVL_INH 6
`define MPC_SW_KEEP_ADDR 7
`define MPC_SW_SLIP 8

// ==========================================================
// wishbone register map (byte addresses)
`define MPC_REG_CTRL 8'h00
`define MPC_REG_STATUS 8'h04
`define MPC_MEM_WIN_TAG 2'h1
`define MPC_CTRL_LOCAL 0
`define MPC_CTRL_RST 1'h0

`endif

// ### mpc_pkg.sv
`include "mpc_defines.svh"

package mpc_pkg;

	// ==========================================================
	// execution sequencer states, one-hot
	typedef enum logic [2:0] {
		st_idle = 3'h1,
		st_run = 3'h2,
		st_halt = 3'h4
	} mpc_state_e;

	// ==========================================================
	// wishbone carriers
	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} mpc_wb_req_s;

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
	} mpc_wb_rsp_s;

	// ==========================================================
	// towards the main sequencer
	typedef struct packed {
		logic start;
		logic abort;
		logic addr_clear;
		logic second;
		logic [`MPC_WORD_W-1:0] op_word;
		logic [`MPC_WORD_W-1:0] addr_word;
		logic [`MPC_WORD_W-1:0] data_word;
	} mpc_exec_s;

	typedef struct packed {
		logic stop_on_check_error;
		logic one_sector_only;
		logic repeat_head_or_sector;
		logic overlap_seek_inhibit;
		logic slip_request;
	} mpc_mode_s;

	// ==========================================================
	// module state
	typedef struct packed {
		logic [`MPC_PIN_W-1:0] s1;
		logic [`MPC_PIN_W-1:0] s2;
		logic [`MPC_PIN_W-1:0] s3;
		logic [`MPC_PIN_W-1:0] pulse;
	} mpc_sync_s;

	typedef struct packed {
		logic [15:0][`MPC_WORD_W-1:0] mem;
		logic [`MPC_PTR_W-1:0] ptr;
		logic [`MPC_WORD_W-1:0] disp;
		mpc_state_e st;
		logic next2;
		logic chained;
		logic halted_err;
		logic local_mode;
		logic ack;
		logic [31:0] rdat;
		mpc_exec_s ex;
		mpc_mode_s md;
	} mpc_main_s;

endpackage : mpc_pkg

// ### mpc_panel_sync.sv
`timescale 1ns/1ps
`include "mpc_defines.svh"

module mpc_panel_sync (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [`MPC_PIN_W-1:0] pins,
	output logic [`MPC_PIN_W-1:0] level,
	output logic [`MPC_PIN_W-1:0] rise
);

	mpc_pkg::mpc_sync_s q_ff;
	mpc_pkg::mpc_sync_s nxt_q;

	// ==========================================================
	// two-stage synchroniser, then a rising-edge detector
	always_comb begin
		nxt_q = q_ff;
		nxt_q.s1 = pins;
		nxt_q.s2 = q_ff.s1;
		nxt_q.s3 = q_ff.s2;
		nxt_q.pulse = q_ff.s2 & ~q_ff.s3;
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			q_ff <= '0;
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign level = q_ff.s2;
	assign rise = q_ff.pulse;

	// ==========================================================
	// checks
	property p_one_pulse;
		@(posedge clock) disable iff (!rst_n)
		(rise != '0) |=> ((rise & $past(rise)) == '0);
	endproperty
	a_one_pulse: assert property (p_one_pulse)
		else $error("button pulse lasted more than one cycle");

endmodule : mpc_panel_sync

// ### mpc_operator_model.sv
`timescale 1ns/1ps

// ==========================================================
// field engineer at the panel: clean presses, held well past
// the synchroniser depth so the block sees every one of them
module mpc_operator_model (
	input wire logic clock,
	output logic [4:0] buttons,
	output logic [8:0] switches,
	output logic [15:0] data
);
	initial begin
		buttons = '0;
		switches = '0;
		data = '0;
	end

	// low gap of 8 cycles keeps presses apart by more than 4
	task automatic press(input int k);
		@(posedge clock);
		buttons[k] <= 1'b1;
		repeat (6) @(posedge clock);
		buttons[k] <= 1'b0;
		repeat (8) @(posedge clock);
	endtask : press

	task automatic set(input logic [8:0] s, input logic [15:0] d);
		@(posedge clock);
		switches <= s;
		data <= d;
		repeat (6) @(posedge clock);
	endtask : set
endmodule : mpc_operator_model

// ### mpc_tb.sv
`timescale 1ns/1ps

module tb;
	logic clock;
	logic arst_n;
	logic op_done;
	logic check_error;
	mpc_pkg::mpc_wb_req_s wb_req;
	mpc_pkg::mpc_wb_rsp_s wb_rsp;
	mpc_pkg::mpc_exec_s exec;
	mpc_pkg::mpc_exec_s last;
	mpc_pkg::mpc_mode_s mode;
	logic [4:0] btn;
	logic [8:0] sw;
	logic [15:0] dsw;
	logic [15:0] disp;
	logic [3:0] ptr;
	logic [15:0] exp_mem [16];
	logic [31:0] q;
	logic s;
	int n_mismatch = 0;
	int n_tests = 0;
	int n_start = 0;
	int n_abort = 0;
	int c;
	int a;

	mpc_maint_panel u_mpc_maint_panel (.clock(clock), .arst_n(arst_n),
		.wb_req(wb_req), .wb_rsp(wb_rsp), .panel_buttons(btn),
		.panel_switches(sw), .data_switches(dsw), .op_done(op_done),
		.check_error(check_error), .exec(exec), .mode(mode),
		.display_lamps(disp), .pointer_lamps(ptr));
	mpc_operator_model u_mpc_operator_model (.clock(clock),
		.buttons(btn), .switches(sw), .data(dsw));

	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ==========================================================
	// one-cycle pulses are caught mid-cycle, away from the edge
	always @(negedge clock) begin
		if (exec.start === 1'b1) begin
			n_start++;
			last = exec;
		end
		if (exec.abort === 1'b1)
			n_abort++;
	end

	// ==========================================================
	// helpers
	function automatic logic [3:0] nxt_ptr(input logic [3:0] p);
		return p + 4'h1;
	endfunction : nxt_ptr

	task automatic chk(input logic [31:0] got, input logic [31:0] e,
		input string m);
		n_tests++;
		if (got !== e) begin
			n_mismatch++;
			$display("Error %0t: %s got %h exp %h", $time, m, got, e);
		end
	endtask : chk

	task automatic wb(input logic we, input logic [7:0] ad,
		input logic [31:0] d);
		int n;
		logic [3:0] sl;
		n = 0;
		// reads ignore the byte enables, writes need sel[0]
		sl = 4'($urandom) | {3'h0, we};
		@(posedge clock);
		wb_req <= {2'h3, we, ad, sl, d};
		// ack is seen here as it stood just before this edge
		do begin
			@(posedge clock);
			n++;
		end while (wb_rsp.ack !== 1'b1 && n < 20);
		q = wb_rsp.dat;
		if (wb_rsp.ack !== 1'b1) begin
			n_mismatch++;
			$display("Error %0t: no bus acknowledge", $time);
		end
		wb_req <= '0;
		@(posedge clock);
	endtask : wb

	task automatic rd(input logic [7:0] ad, input logic [31:0] e,
		input string m);
		wb(1'b0, ad, 32'h0);
		chk(q, e, m);
	endtask : rd

	task automatic pulse(input logic err);
		@(posedge clock);
		if (err)
			check_error <= 1'b1;
		else
			op_done <= 1'b1;
		@(posedge clock);
		op_done <= 1'b0;
		check_error <= 1'b0;
		repeat (4) @(posedge clock);
	endtask : pulse

	// stop-on-error and the switches that never steer the sequencer are drawn at random
	task automatic setr(input logic [8:0] s, input logic [15:0] d);
		logic [8:0] v;
		v = s | (9'($urandom) & 9'h162);
		u_mpc_operator_model.set(v, d);
		chk(mode, {v[1], v[2], v[5], v[6], v[8]}, "mode");
	endtask : setr

	task automatic chk_ex(input logic sec, input logic clr);
		logic [3:0] b;
		b = {sec, 3'h0};
		chk(last.second, sec, "instruction slot");
		chk(last.op_word, exp_mem[b], "op word");
		chk(last.addr_word, exp_mem[b + 4'h1], "address word");
		chk(last.data_word, exp_mem[b + 4'h2], "data word");
		chk(last.addr_clear, clr, "address clear");
	endtask : chk_ex

	task automatic print_verdict;
		$display("tests %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : print_verdict

	initial begin
		repeat (30000) @(posedge clock);
		n_mismatch++;
		print_verdict();
	end

	// ==========================================================
	// main sequence
	initial begin
		arst_n = 1'b0;
		op_done = 1'b0;
		check_error = 1'b0;
		wb_req = '0;
		for (int i = 0; i < 16; i++)
			exp_mem[i] = '0;
		void'($urandom(32'hD189ED25));
		repeat (16) @(posedge clock);
		arst_n <= 1'b1;
		repeat (8) @(posedge clock);
		c = $urandom;
		u_mpc_operator_model.set(c[8:0], c[31:16]);
		u_mpc_operator_model.press(0);
		chk(ptr, 4'h0, "remote load");
		chk(mode, 5'h0, "remote mode");
		rd(8'h40, 32'h0, "remote memory");
		wb(1'b1, 8'h00, {31'($urandom), 1'b1});
		rd(8'h00, 32'h1, "control");
		rd(8'hFC, 32'h0, "unmapped");
		chk(mode, {c[1], c[2], c[5], c[6], c[8]}, "mode");
		for (int i = 0; i < 16; i++) begin
			c = $urandom;
			exp_mem[i] = c[15:0];
			setr(9'h001, c[15:0]);
			u_mpc_operator_model.press(0);
			chk(ptr, nxt_ptr(i[3:0]), "load pointer");
			chk(disp, exp_mem[nxt_ptr(i[3:0])], "load lamps");
		end
		for (int i = 0; i < 16; i++)
			rd({2'h1, i[3:0], 2'h0}, exp_mem[i], "memory");
		// a full lap of steps, the last one wraps from 15 to 0
		setr(9'h001, 16'($urandom));
		for (int i = 0; i < 16; i++) begin
			u_mpc_operator_model.press(2);
			chk(ptr, nxt_ptr(i[3:0]), "step walk");
			chk(disp, exp_mem[nxt_ptr(i[3:0])], "step walk lamps");
		end
		setr(9'h000, 16'($urandom));
		u_mpc_operator_model.press(2);
		chk(ptr, 4'h0, "step display off");
		setr(9'h001, 16'($urandom));
		u_mpc_operator_model.press(2);
		chk(ptr, 4'h1, "step pointer");
		chk(disp, exp_mem[1], "step lamps");
		u_mpc_operator_model.press(1);
		exp_mem[1] = '0;
		chk(disp, 16'h0, "clear lamps");
		rd(8'h44, 32'h0, "cleared word");
		rd(8'h48, exp_mem[2], "other word");
		setr(9'h000, 16'($urandom));
		u_mpc_operator_model.press(1);
		chk(ptr, 4'h0, "clear pointer");
		chk(disp, 16'h0, "clear blank");
		rd(8'h48, exp_mem[2], "clear keeps memory");
		// plain run; step while running must not move the pointer
		setr(9'h001, 16'($urandom));
		c = n_start;
		u_mpc_operator_model.press(3);
		chk(n_start, c + 1, "one start");
		chk_ex(1'b0, 1'b1);
		u_mpc_operator_model.press(2);
		chk(ptr, 4'h0, "step while running");
		pulse(1'b0);
		rd(8'h04, 32'h00000010, "status");
		chk(q[6:4], 3'h1, "idle after done");
		// start, done, start: never clear in between
		setr(9'h088, 16'($urandom));
		u_mpc_operator_model.press(3);
		s = 1'b0;
		chk_ex(s, 1'b0);
		pulse(1'b0);
		u_mpc_operator_model.press(3);
		chk_ex(!s, 1'b0);
		pulse(1'b0);
		setr(9'h018, 16'($urandom));
		c = n_start;
		u_mpc_operator_model.press(3);
		s = last.second;
		pulse(1'b0);
		chk_ex(!s, 1'b0);
		pulse(1'b0);
		chk(n_start, c + 2, "chain runs once");
		setr(9'h004, 16'($urandom));
		c = n_start;
		u_mpc_operator_model.press(3);
		pulse(1'b0);
		chk(n_start, c + 1, "single sector ends");
		setr(9'h014, 16'($urandom));
		u_mpc_operator_model.press(3);
		s = last.second;
		pulse(1'b0);
		chk(n_start, c + 3, "sector repeat");
		chk(last.second, s, "same instruction");
		u_mpc_operator_model.press(4);
		setr(9'h01C, 16'($urandom));
		c = n_start;
		u_mpc_operator_model.press(3);
		s = last.second;
		pulse(1'b0);
		chk_ex(!s, 1'b0);
		pulse(1'b0);
		chk_ex(s, 1'b0);
		chk(n_start, c + 3, "endless swap");
		u_mpc_operator_model.press(4);
		setr(9'h01A, 16'($urandom));
		c = n_start;
		a = n_abort;
		u_mpc_operator_model.press(3);
		s = last.second;
		pulse(1'b1);
		chk(n_abort, a + 1, "error abort");
		chk(n_start, c + 2, "error runs other");
		chk_ex(!s, 1'b0);
		pulse(1'b0);
		setr(9'h002, 16'($urandom));
		a = n_abort;
		u_mpc_operator_model.press(3);
		pulse(1'b1);
		chk(n_abort, a + 1, "halt abort");
		rd(8'h04, 32'h00000440, "status");
		chk(q[10], 1'b1, "halted on error");
		chk(q[6:4], 3'h4, "halt state");
		print_verdict();
	end
endmodule : tb
